//--- bench/blg_regs_tb.sv
// self-checking apb testbench of the black level and gain register bank
`timescale 1ns/1ps
module blg_regs_tb;
  // ****************************************
  // design connections
  // ****************************************
  logic        clk_i, srst_i, psel_i, penable_i, pwrite_i; // clock, reset, apb controls
  logic [9:0]  paddr_i;                                    // byte address
  logic [31:0] pwdata_i, prdata_o, rd_s;                   // apb data, scratch read
  logic [3:0]  pstrb_i;                                    // byte strobes
  logic        pready_o, pslverr_o, err_s;                 // apb answer, scratch error
  logic [7:0]  loop_black_i, black_target_level_o, black_correction_o;
  logic        black_comp_disable_o;                       // loop off flag
  logic [2:0]  black_converge_rate_o;                      // rate field
  logic [6:0]  analog_gain_o;                              // gain code
  logic [1:0]  chan0_map_o, chan1_map_o, chan2_map_o, chan3_map_o;
  int          miscompares = 0, checked = 0, cycles = 0;   // counters
  blg_regs i_blg_regs (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .loop_black_i(loop_black_i),
    .black_comp_disable_o(black_comp_disable_o), .black_converge_rate_o(black_converge_rate_o),
    .black_target_level_o(black_target_level_o), .analog_gain_o(analog_gain_o), .chan0_map_o(chan0_map_o),
    .chan1_map_o(chan1_map_o), .chan2_map_o(chan2_map_o), .chan3_map_o(chan3_map_o),
    .black_correction_o(black_correction_o));
  // ****************************************
  // clock and hang guard
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // hang guard: far above the roughly 170 cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  // verdict and end of run
  task complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one compare, counted
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, then access held until pready
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] st,
           output logic [31:0] rd, output logic er);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= {idx, 2'b00};
    pwdata_i  <= wd;
    pstrb_i   <= st;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    // access phase held until pready; only the hang guard ends a stuck wait
    while (pready_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // full-word write
  task wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, 4'hF, rd_s, err_s);
  endtask
  // read, then compare data and error flag
  task rchk(input logic [7:0] idx, input logic [31:0] exp, input logic ee);
    apb(1'b0, idx, 32'h0, 4'h0, rd_s, err_s);
    chk(rd_s, exp);
    chk({31'h0, err_s}, {31'h0, ee});
  endtask
  // let register and correction updates land
  task settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    srst_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 10'h000; pwdata_i = 32'h0; pstrb_i = 4'h0; loop_black_i = 8'h3C;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    settle();
    // reset values and reset-time outputs
    rchk(blg_pkg::IDX_BLACK_LEVEL_CONFIG, 32'h0F, 1'b0);
    chk({31'h0, black_comp_disable_o}, 32'h1);
    rchk(blg_pkg::IDX_BLACK_LEVEL_TARGET, 32'h10, 1'b0);
    rchk(blg_pkg::IDX_ANALOG_GAIN, 32'h00, 1'b0);
    rchk(blg_pkg::IDX_MANUAL_BLACK_OFFSET, 32'h00, 1'b0);
    rchk(blg_pkg::IDX_GAIN_CHANNEL_MAP, 32'h1B, 1'b0);
    chk({24'h0, chan0_map_o, chan1_map_o, chan2_map_o, chan3_map_o}, 32'h1B);
    // disabled loop applies the manual offset; a blank strobe is ignored
    wr(blg_pkg::IDX_MANUAL_BLACK_OFFSET, 32'hA5);
    apb(1'b1, blg_pkg::IDX_MANUAL_BLACK_OFFSET, 32'h11, 4'h0, rd_s, err_s);
    settle();
    chk({24'h0, black_correction_o}, 32'hA5);
    rchk(blg_pkg::IDX_MANUAL_BLACK_OFFSET, 32'hA5, 1'b0);
    // every rate code with the loop enabled, loop result passed on
    for (int r = 0; r < 8; r++) begin
      wr(blg_pkg::IDX_BLACK_LEVEL_CONFIG, 32'(r));
      settle();
      chk({28'h0, black_comp_disable_o, black_converge_rate_o}, 32'(r));
      rchk(blg_pkg::IDX_BLACK_LEVEL_CONFIG, 32'(r), 1'b0);
    end
    chk({24'h0, black_correction_o}, 32'h3C);
    // status word: loop running flag above the applied correction
    rchk(blg_pkg::IDX_BLACK_STATUS, 32'h13C, 1'b0);
    wr(blg_pkg::IDX_BLACK_LEVEL_CONFIG, 32'h08);
    settle();
    chk({31'h0, black_comp_disable_o}, 32'h1);
    rchk(blg_pkg::IDX_BLACK_STATUS, 32'hA5, 1'b0);
    // full-range target, reserved gain bit reads zero
    wr(blg_pkg::IDX_BLACK_LEVEL_TARGET, 32'hFF);
    wr(blg_pkg::IDX_ANALOG_GAIN, 32'hFF);
    settle();
    chk({24'h0, black_target_level_o}, 32'hFF);
    chk({25'h0, analog_gain_o}, 32'h7F);
    rchk(blg_pkg::IDX_ANALOG_GAIN, 32'h7F, 1'b0);
    // channel map fields, then monochrome clearing by the host
    wr(blg_pkg::IDX_GAIN_CHANNEL_MAP, 32'hE4);
    settle();
    chk({24'h0, chan0_map_o, chan1_map_o, chan2_map_o, chan3_map_o}, 32'hE4);
    wr(blg_pkg::IDX_GAIN_CHANNEL_MAP, 32'h00);
    rchk(blg_pkg::IDX_GAIN_CHANNEL_MAP, 32'h00, 1'b0);
    // unmapped place: error, reads zero, write leaves target alone
    apb(1'b1, 8'h43, 32'h55, 4'hF, rd_s, err_s);
    chk({31'h0, err_s}, 32'h1);
    rchk(8'h43, 32'h0, 1'b1);
    rchk(blg_pkg::IDX_BLACK_LEVEL_TARGET, 32'hFF, 1'b0);
    // mid-run reset brings every written register back to its reset value
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    settle();
    rchk(blg_pkg::IDX_BLACK_LEVEL_CONFIG, 32'h0F, 1'b0);
    rchk(blg_pkg::IDX_BLACK_LEVEL_TARGET, 32'h10, 1'b0);
    rchk(blg_pkg::IDX_ANALOG_GAIN, 32'h00, 1'b0);
    rchk(blg_pkg::IDX_MANUAL_BLACK_OFFSET, 32'h00, 1'b0);
    rchk(blg_pkg::IDX_GAIN_CHANNEL_MAP, 32'h1B, 1'b0);
    chk({24'h0, black_correction_o}, 32'h00);
    complete_run();
  end
endmodule

//--- design/blg_regs.sv
// apb register bank for black level compensation, analog gain and channel map
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
// ****************************************
// ****************************************
module blg_regs (
  input  wire logic        clk_i,                  // 250 MHz clock
  input  wire logic        srst_i,                 // synchronous reset, active high
  input  wire logic        psel_i,                 // apb select
  input  wire logic        penable_i,              // apb access phase
  input  wire logic        pwrite_i,               // apb direction
  input  wire logic [9:0]  paddr_i,                // apb byte address
  input  wire logic [31:0] pwdata_i,               // apb write data
  input  wire logic [3:0]  pstrb_i,                // apb byte strobes
  output logic      [31:0] prdata_o,               // apb read data
  output logic             pready_o,               // apb ready
  output logic             pslverr_o,              // apb error on unmapped address
  input  wire logic [7:0]  loop_black_i,           // servo loop's own black result
  output logic             black_comp_disable_o,   // 1 = loop off
  output logic      [2:0]  black_converge_rate_o,  // loop convergence rate
  output logic      [7:0]  black_target_level_o,   // loop target
  output logic      [6:0]  analog_gain_o,          // gain code, 0.125 dB steps
  output logic      [1:0]  chan0_map_o,            // gain channel 0 map
  output logic      [1:0]  chan1_map_o,            // gain channel 1 map
  output logic      [1:0]  chan2_map_o,            // gain channel 2 map
  output logic      [1:0]  chan3_map_o,            // gain channel 3 map
  output logic      [7:0]  black_correction_o      // applied black level correction
);
  // ****************************************
  // storage
  // ****************************************
  logic [3:0] black_level_config;   // disable bit and rate
  logic [7:0] black_level_target;   // target level
  logic [6:0] analog_gain;          // gain code
  logic [7:0] manual_black_offset;  // manual level
  logic [7:0] gain_channel_map;     // packed channel maps
  logic [7:0] black_correction;     // selected correction
  logic [7:0] reg_idx;              // word index of the access
  logic       aligned;              // low address bits zero
  logic       hit;                  // address maps to a register
  logic       wr_en;                // write takes effect now
  logic [7:0] wbyte;                // low write byte

  // ****************************************
  // address decode
  // ****************************************
  assign reg_idx = paddr_i[9:2];
  assign aligned = (paddr_i[1:0] == 2'h0);
  always_comb begin
    // mapped indices only
    hit = aligned && (reg_idx == blg_pkg::IDX_BLACK_LEVEL_CONFIG || reg_idx == blg_pkg::IDX_BLACK_LEVEL_TARGET ||
                      reg_idx == blg_pkg::IDX_ANALOG_GAIN || reg_idx == blg_pkg::IDX_MANUAL_BLACK_OFFSET ||
                      reg_idx == blg_pkg::IDX_GAIN_CHANNEL_MAP || reg_idx == blg_pkg::IDX_BLACK_STATUS);
  end
  // zero-wait slave
  assign pready_o  = 1'b1;
  // error only in the access phase of an unmapped access
  assign pslverr_o = psel_i && penable_i && !hit;
  assign wr_en     = psel_i && penable_i && pwrite_i && pstrb_i[0];
  assign wbyte     = pwdata_i[7:0];

  // ****************************************
  // register writes
  // ****************************************
  // config: disable bit and rate
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      black_level_config <= blg_pkg::RST_BLACK_LEVEL_CONFIG[3:0];
    end else if (wr_en && aligned && reg_idx == blg_pkg::IDX_BLACK_LEVEL_CONFIG) begin
      black_level_config <= wbyte[3:0];
    end
  end
  // target level
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      black_level_target <= blg_pkg::RST_BLACK_LEVEL_TARGET;
    end else if (wr_en && aligned && reg_idx == blg_pkg::IDX_BLACK_LEVEL_TARGET) begin
      black_level_target <= wbyte;
    end
  end
  // gain code, bit 7 dropped
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      analog_gain <= blg_pkg::RST_ANALOG_GAIN[6:0];
    end else if (wr_en && aligned && reg_idx == blg_pkg::IDX_ANALOG_GAIN) begin
      analog_gain <= wbyte[blg_pkg::GAIN_CODE_MSB:0];
    end
  end
  // manual offset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      manual_black_offset <= blg_pkg::RST_MANUAL_BLACK_OFFSET;
    end else if (wr_en && aligned && reg_idx == blg_pkg::IDX_MANUAL_BLACK_OFFSET) begin
      manual_black_offset <= wbyte;
    end
  end
  // channel map; monochrome setup writes zero here
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gain_channel_map <= blg_pkg::RST_GAIN_CHANNEL_MAP;
    end else if (wr_en && aligned && reg_idx == blg_pkg::IDX_GAIN_CHANNEL_MAP) begin
      gain_channel_map <= wbyte;
    end
  end

  // ****************************************
  // correction select
  // ****************************************
  // manual offset while the loop is off, loop result otherwise
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      black_correction <= blg_pkg::RST_MANUAL_BLACK_OFFSET;
    end else if (black_level_config[blg_pkg::CFG_DISABLE_BIT]) begin
      black_correction <= manual_black_offset;
    end else begin
      black_correction <= loop_black_i;
    end
  end

  // ****************************************
  // read data, captured in the setup phase
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= 32'h0000_0000;
      if (aligned) begin
        unique case (reg_idx)
          blg_pkg::IDX_BLACK_LEVEL_CONFIG:  prdata_o[3:0] <= black_level_config;
          blg_pkg::IDX_BLACK_LEVEL_TARGET:  prdata_o[7:0] <= black_level_target;
          blg_pkg::IDX_ANALOG_GAIN:         prdata_o[6:0] <= analog_gain;
          blg_pkg::IDX_MANUAL_BLACK_OFFSET: prdata_o[7:0] <= manual_black_offset;
          blg_pkg::IDX_GAIN_CHANNEL_MAP:    prdata_o[7:0] <= gain_channel_map;
          blg_pkg::IDX_BLACK_STATUS: begin
            // applied correction and loop running flag
            prdata_o[7:0]                       <= black_correction;
            prdata_o[blg_pkg::STS_ENABLED_BIT]  <= ~black_level_config[blg_pkg::CFG_DISABLE_BIT];
          end
          default:                          prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign black_comp_disable_o  = black_level_config[blg_pkg::CFG_DISABLE_BIT];
  assign black_converge_rate_o = black_level_config[blg_pkg::CFG_RATE_MSB:0];
  assign black_target_level_o  = black_level_target;
  assign analog_gain_o         = analog_gain;
  assign chan0_map_o           = gain_channel_map[7:6];
  assign chan1_map_o           = gain_channel_map[5:4];
  assign chan2_map_o           = gain_channel_map[3:2];
  assign chan3_map_o           = gain_channel_map[1:0];
  assign black_correction_o    = black_correction;

  // ****************************************
  // assertions
  // ****************************************
  // reset checks look one edge past a reset edge, so no history before the first edge is needed
  a_disable_reset: assert property (@(posedge clk_i) srst_i |=> black_comp_disable_o)
    else $error("loop not disabled after reset");
  a_rate_write: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_en && aligned && reg_idx == blg_pkg::IDX_BLACK_LEVEL_CONFIG
    |=> black_converge_rate_o == $past(pwdata_i[blg_pkg::CFG_RATE_MSB:0]))
    else $error("rate field not written");
  a_target_reset: assert property (@(posedge clk_i)
    srst_i |=> black_target_level_o == blg_pkg::RST_BLACK_LEVEL_TARGET)
    else $error("target reset value wrong");
  a_gain_write: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_en && aligned && reg_idx == blg_pkg::IDX_ANALOG_GAIN
    |=> analog_gain_o == $past(pwdata_i[blg_pkg::GAIN_CODE_MSB:0]))
    else $error("gain code not written");
  a_offset_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    !(wr_en && reg_idx == blg_pkg::IDX_MANUAL_BLACK_OFFSET) |=> $stable(manual_black_offset))
    else $error("offset changed without write");
  a_map_reset: assert property (@(posedge clk_i)
    srst_i |=> {chan0_map_o, chan1_map_o, chan2_map_o, chan3_map_o} == blg_pkg::RST_GAIN_CHANNEL_MAP)
    else $error("channel map reset wrong");
  a_manual_apply: assert property (@(posedge clk_i) disable iff (srst_i)
    black_comp_disable_o ##1 black_comp_disable_o |-> black_correction_o == $past(manual_black_offset))
    else $error("manual offset not applied");
  a_loop_apply: assert property (@(posedge clk_i) disable iff (srst_i)
    !black_comp_disable_o |=> black_correction_o == $past(loop_black_i))
    else $error("loop result not applied");
endmodule

//--- shared/blg_pkg.sv
// constants of the black level and gain configuration register bank
package blg_pkg;
  // ****************************************
  // register indices (byte address is four times the index)
  // ****************************************
  localparam logic [7:0] IDX_BLACK_LEVEL_CONFIG  = 8'h40; // compensation disable bit and rate
  localparam logic [7:0] IDX_BLACK_LEVEL_TARGET  = 8'h41; // target black level
  localparam logic [7:0] IDX_ANALOG_GAIN         = 8'h42; // gain code
  localparam logic [7:0] IDX_MANUAL_BLACK_OFFSET = 8'h46; // manual black level
  localparam logic [7:0] IDX_GAIN_CHANNEL_MAP    = 8'h4A; // four 2-bit channel maps
  localparam logic [7:0] IDX_BLACK_STATUS        = 8'h4C; // read-only applied correction
  localparam int         ADDR_W                  = 10;    // apb address bits decoded
  // ****************************************
  // field positions
  // ****************************************
  localparam int         CFG_DISABLE_BIT         = 3;     // 1 = loop off
  localparam int         CFG_RATE_MSB            = 2;     // rate field top bit
  localparam int         GAIN_CODE_MSB           = 6;     // gain code top bit
  localparam int         STS_ENABLED_BIT         = 8;     // status: loop running
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_BLACK_LEVEL_CONFIG  = 8'h0F; // disabled, fastest rate code
  localparam logic [7:0] RST_BLACK_LEVEL_TARGET  = 8'h10;
  localparam logic [7:0] RST_ANALOG_GAIN         = 8'h00;
  localparam logic [7:0] RST_MANUAL_BLACK_OFFSET = 8'h00;
  localparam logic [7:0] RST_GAIN_CHANNEL_MAP    = 8'h1B;
endpackage
